// file: hw/stc_top.sv
// Threshold and channel setup registers of a 3-axis field sensor, with limit checking.
// Assumes a register port and result stream from logic on the same clock.
`timescale 1ns/1ns
module stc_top (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [2:0] band_select_in,
  input wire logic [7:0] gain_value_in,
  input wire logic result_valid_in,
  input wire logic [1:0] result_axis_in,
  input wire logic [11:0] result_data_in,
  output logic angle_on_out,
  output logic [1:0] angle_first_out,
  output logic [1:0] angle_second_out,
  output logic [7:0] gain_first_out,
  output logic [7:0] gain_second_out,
  output logic xy_range_double_out,
  output logic z_range_double_out,
  output logic [12:0] x_limit_field_out,
  output logic [12:0] y_limit_field_out,
  output logic [12:0] z_limit_field_out,
  output logic [6:0] temp_limit_code_out,
  output logic temp_channel_on_out,
  output logic [3:0] match_flags_out,
  output logic threshold_event_out
);
  typedef struct packed {
    logic [7:0] setup_two;
    logic [7:0] x_limit;
    logic [7:0] y_limit;
    logic [7:0] z_limit;
    logic [7:0] temp_setup;
    logic [7:0] rdata;
    logic [7:0] gain_first;
    logic [7:0] gain_second;
    logic [1:0] first_ch;
    logic [1:0] second_ch;
    logic [12:0] x_field;
    logic [12:0] y_field;
    logic [12:0] z_field;
    logic [3:0] prev_match;
    logic [2:0] cross_cnt;
    logic event_hit;
  } stc_state_s;

  localparam stc_state_s STATE_RST = '{
    setup_two: stc_pkg::RST_SETUP_TWO,
    x_limit: stc_pkg::RST_LIMIT,
    y_limit: stc_pkg::RST_LIMIT,
    z_limit: stc_pkg::RST_LIMIT,
    temp_setup: stc_pkg::RST_TEMP_SETUP,
    rdata: 8'h00,
    gain_first: 8'h00,
    gain_second: 8'h00,
    first_ch: 2'h0,
    second_ch: 2'h0,
    x_field: 13'h0000,
    y_field: 13'h0000,
    z_field: 13'h0000,
    prev_match: 4'h0,
    cross_cnt: 3'h0,
    event_hit: 1'b0
  };

  stc_state_s state_reg;
  stc_state_s state_next;
  stc_cmp_if cmp_bus ();

  logic direction;
  logic cross_multi;
  logic gain_second_sel;
  logic [1:0] angle_pair;
  logic xy_double;
  logic z_double;
  logic [6:0] temp_code;
  logic crossing;

  // Signed limit code in base-range units, doubled for the wide range
  function automatic logic [12:0] stc_field_scale(input logic [7:0] code, input logic dbl);
    logic signed [12:0] base;
    base = 13'(stc_pkg::stc_code_to_lsb(code));
    return dbl ? base <<< 1 : base;
  endfunction

  // Field decode of the setup registers
  assign direction = state_reg.setup_two[stc_pkg::BIT_DIRECTION];
  assign cross_multi = state_reg.setup_two[stc_pkg::BIT_CROSS_SEL];
  assign gain_second_sel = state_reg.setup_two[stc_pkg::BIT_GAIN_CH];
  assign angle_pair = state_reg.setup_two[stc_pkg::BIT_ANGLE_HI:stc_pkg::BIT_ANGLE_LO];
  assign xy_double = state_reg.setup_two[stc_pkg::BIT_XY_RANGE];
  assign z_double = state_reg.setup_two[stc_pkg::BIT_Z_RANGE];
  assign temp_code = state_reg.temp_setup[stc_pkg::BIT_TEMP_HI:stc_pkg::BIT_TEMP_LO];

  // Limit comparator request
  always_comb begin
    cmp_bus.result = $signed(result_data_in);
    cmp_bus.direction = direction;
    cmp_bus.band_select = band_select_in;
    cmp_bus.is_temp = 1'b0;
    case (result_axis_in)
      stc_pkg::STC_AXIS_X: begin
        cmp_bus.limit_code = state_reg.x_limit;
      end
      stc_pkg::STC_AXIS_Y: begin
        cmp_bus.limit_code = state_reg.y_limit;
      end
      stc_pkg::STC_AXIS_Z: begin
        cmp_bus.limit_code = state_reg.z_limit;
      end
      default: begin
        cmp_bus.limit_code = {1'b0, temp_code};
        cmp_bus.is_temp = 1'b1;
      end
    endcase
  end

  stc_limit_cmp limit_check (
    .cmp_port(cmp_bus.checker_end)
  );

  assign crossing = result_valid_in && cmp_bus.active && cmp_bus.match &&
                    !state_reg.prev_match[result_axis_in];

  always_comb begin
    state_next = state_reg;
    state_next.event_hit = 1'b0;

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        stc_pkg::OFF_SETUP_TWO: begin
          state_next.setup_two = reg_wdata_in & stc_pkg::SETUP_TWO_WMASK;
        end
        stc_pkg::OFF_X_LIMIT: begin
          state_next.x_limit = reg_wdata_in;
        end
        stc_pkg::OFF_Y_LIMIT: begin
          state_next.y_limit = reg_wdata_in;
        end
        stc_pkg::OFF_Z_LIMIT: begin
          state_next.z_limit = reg_wdata_in;
        end
        stc_pkg::OFF_TEMP_SETUP: begin
          state_next.temp_setup = reg_wdata_in;
        end
        default: begin
          state_next.rdata = state_reg.rdata;
        end
      endcase
    end

    // Register reads, unmapped offsets read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        stc_pkg::OFF_SETUP_TWO: begin
          state_next.rdata = state_reg.setup_two;
        end
        stc_pkg::OFF_X_LIMIT: begin
          state_next.rdata = state_reg.x_limit;
        end
        stc_pkg::OFF_Y_LIMIT: begin
          state_next.rdata = state_reg.y_limit;
        end
        stc_pkg::OFF_Z_LIMIT: begin
          state_next.rdata = state_reg.z_limit;
        end
        stc_pkg::OFF_TEMP_SETUP: begin
          state_next.rdata = state_reg.temp_setup;
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end

    // Angle pair channel selection
    case (angle_pair)
      stc_pkg::STC_ANGLE_XY: begin
        state_next.first_ch = stc_pkg::STC_AXIS_X;
        state_next.second_ch = stc_pkg::STC_AXIS_Y;
      end
      stc_pkg::STC_ANGLE_YZ: begin
        state_next.first_ch = stc_pkg::STC_AXIS_Y;
        state_next.second_ch = stc_pkg::STC_AXIS_Z;
      end
      stc_pkg::STC_ANGLE_XZ: begin
        state_next.first_ch = stc_pkg::STC_AXIS_X;
        state_next.second_ch = stc_pkg::STC_AXIS_Z;
      end
      default: begin
        state_next.first_ch = stc_pkg::STC_AXIS_X;
        state_next.second_ch = stc_pkg::STC_AXIS_X;
      end
    endcase

    // Gain correction routing, nothing applied while angle is off
    state_next.gain_first = 8'h00;
    state_next.gain_second = 8'h00;
    if (angle_pair != stc_pkg::STC_ANGLE_OFF) begin
      if (gain_second_sel) begin
        state_next.gain_second = gain_value_in;
      end else begin
        state_next.gain_first = gain_value_in;
      end
    end

    // Limits in base-range result units, doubled by range bits
    state_next.x_field = stc_field_scale(state_reg.x_limit, xy_double);
    state_next.y_field = stc_field_scale(state_reg.y_limit, xy_double);
    state_next.z_field = stc_field_scale(state_reg.z_limit, z_double);

    // Per-axis match tracking, inactive limits clear their flag
    if (result_valid_in) begin
      state_next.prev_match[result_axis_in] = cmp_bus.active && cmp_bus.match;
    end

    // Crossing count before the event
    if (crossing) begin
      if (!cross_multi) begin
        state_next.event_hit = 1'b1;
        state_next.cross_cnt = 3'h0;
      end else if (state_reg.cross_cnt + stc_pkg::CROSS_CNT_ONE ==
                   stc_pkg::CROSS_MULTI_COUNT) begin
        state_next.event_hit = 1'b1;
        state_next.cross_cnt = 3'h0;
      end else begin
        state_next.cross_cnt = state_reg.cross_cnt + stc_pkg::CROSS_CNT_ONE;
      end
    end
    if (!cross_multi && !crossing) begin
      state_next.cross_cnt = 3'h0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign reg_rdata_out = state_reg.rdata;
  assign angle_on_out = (angle_pair != stc_pkg::STC_ANGLE_OFF);
  assign angle_first_out = state_reg.first_ch;
  assign angle_second_out = state_reg.second_ch;
  assign gain_first_out = state_reg.gain_first;
  assign gain_second_out = state_reg.gain_second;
  assign xy_range_double_out = xy_double;
  assign z_range_double_out = z_double;
  assign x_limit_field_out = state_reg.x_field;
  assign y_limit_field_out = state_reg.y_field;
  assign z_limit_field_out = state_reg.z_field;
  assign temp_limit_code_out = temp_code;
  assign temp_channel_on_out = state_reg.temp_setup[stc_pkg::BIT_TEMP_ON];
  assign match_flags_out = state_reg.prev_match;
  assign threshold_event_out = state_reg.event_hit;
endmodule // stc_top

// file: pkg/stc_pkg.sv
// Shared constants, types and helpers of the sensor threshold setup block.
// Assumes one 20 MHz clock domain and a register port fed by the serial front end.
package stc_pkg;
  // Register offsets
  localparam logic [7:0] OFF_SETUP_TWO = 8'h03;
  localparam logic [7:0] OFF_X_LIMIT = 8'h04;
  localparam logic [7:0] OFF_Y_LIMIT = 8'h05;
  localparam logic [7:0] OFF_Z_LIMIT = 8'h06;
  localparam logic [7:0] OFF_TEMP_SETUP = 8'h07;
  // Values after reset, and the setup write mask
  localparam logic [7:0] RST_SETUP_TWO = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RST_TEMP_SETUP = 8'h00;
  localparam logic [7:0] SETUP_TWO_WMASK = 8'h7F;
  // Field positions
  localparam int BIT_CROSS_SEL = 6;
  localparam int BIT_DIRECTION = 5;
  localparam int BIT_GAIN_CH = 4;
  localparam int BIT_ANGLE_HI = 3;
  localparam int BIT_ANGLE_LO = 2;
  localparam int BIT_XY_RANGE = 1;
  localparam int BIT_Z_RANGE = 0;
  localparam int BIT_TEMP_ON = 0;
  localparam int BIT_TEMP_HI = 7;
  localparam int BIT_TEMP_LO = 1;
  // Comparison constants
  localparam logic [6:0] TEMP_CODE_MIN = 7'h1A;
  localparam logic [6:0] TEMP_CODE_MAX = 7'h34;
  localparam logic [2:0] BAND_SIGNED = 3'h0;
  localparam logic [2:0] BAND_PAIR = 3'h1;
  localparam logic [2:0] BAND_FIRST_WIDE = 3'h2;
  localparam logic [11:0] BAND_MIN_LSB = 12'h008;
  localparam logic [2:0] CROSS_MULTI_COUNT = 3'h4;
  localparam logic [2:0] CROSS_CNT_ONE = 3'h1;

  typedef enum logic [1:0] {
    STC_AXIS_X = 2'h0,
    STC_AXIS_Y = 2'h1,
    STC_AXIS_Z = 2'h2,
    STC_AXIS_T = 2'h3
  } stc_axis_e;

  typedef enum logic [1:0] {
    STC_ANGLE_OFF = 2'h0,
    STC_ANGLE_XY = 2'h1,
    STC_ANGLE_YZ = 2'h2,
    STC_ANGLE_XZ = 2'h3
  } stc_angle_e;

  // Signed limit code to 12-bit result units
  function automatic logic signed [11:0] stc_code_to_lsb(input logic [7:0] code);
    return {code, 4'h0};
  endfunction

  // Seven-bit band magnitude to 12-bit result units
  function automatic logic signed [11:0] stc_half_to_lsb(input logic [7:0] code);
    return {1'b0, code[6:0], 4'h0};
  endfunction
endpackage

// file: pkg/stc_cmp_if.sv
// Link between the setup block and its limit comparator.
// Assumes both ends sit in the same clock domain; the comparator is combinational.
`timescale 1ns/1ns
interface stc_cmp_if;
  logic [7:0] limit_code;
  logic signed [11:0] result;
  logic is_temp;
  logic direction;
  logic [2:0] band_select;
  logic match;
  logic active;
  modport requester (
    output limit_code, result, is_temp, direction, band_select,
    input match, active
  );
  modport checker_end (
    input limit_code, result, is_temp, direction, band_select,
    output match, active
  );
endinterface

// file: hw/stc_limit_cmp.sv
// Combinational limit check of one result against its limit code.
// Assumes the requester holds all inputs stable within the cycle.
`timescale 1ns/1ns
module stc_limit_cmp (
  stc_cmp_if.checker_end cmp_port
);
  logic signed [11:0] thr;
  logic signed [11:0] half;
  logic signed [12:0] upper;
  logic [11:0] band;
  logic [6:0] tcode;
  logic [6:0] tres;
  logic outside;

  always_comb begin
    thr = stc_pkg::stc_code_to_lsb(cmp_port.limit_code);
    half = stc_pkg::stc_half_to_lsb(cmp_port.limit_code);
    band = stc_pkg::BAND_MIN_LSB << (cmp_port.band_select - stc_pkg::BAND_FIRST_WIDE);
    upper = 13'(thr) + $signed({1'b0, band});
    outside = (cmp_port.result > half) || (cmp_port.result < -half);
    tcode = cmp_port.limit_code[6:0];
    // Out-of-range temperature codes clamped to valid span
    if (tcode < stc_pkg::TEMP_CODE_MIN) begin
      tcode = stc_pkg::TEMP_CODE_MIN;
    end else if (tcode > stc_pkg::TEMP_CODE_MAX) begin
      tcode = stc_pkg::TEMP_CODE_MAX;
    end
    tres = cmp_port.result[6:0];
    cmp_port.active = (cmp_port.limit_code != 8'h00);
    if (cmp_port.is_temp) begin
      cmp_port.match = cmp_port.direction ? (tres < tcode) : (tres > tcode);
    end else begin
      case (cmp_port.band_select)
        stc_pkg::BAND_SIGNED: begin
          cmp_port.match = cmp_port.direction ? (cmp_port.result < thr) :
                           (cmp_port.result > thr);
        end
        stc_pkg::BAND_PAIR: begin
          cmp_port.match = cmp_port.direction ? !outside : outside;
        end
        default: begin
          cmp_port.match = 13'(cmp_port.result) > upper;
        end
      endcase
    end
  end
endmodule // stc_limit_cmp

// file: sim/stc_assertions.sv
// Port checks of the threshold setup block.
// Assumes binding to stc_top on its single clock and active-low reset.
`timescale 1ns/1ns
module stc_checker (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic result_valid_in,
  input wire logic [1:0] result_axis_in,
  input wire logic angle_on_out,
  input wire logic [7:0] gain_first_out,
  input wire logic [7:0] gain_second_out,
  input wire logic xy_range_double_out,
  input wire logic z_range_double_out,
  input wire logic [12:0] x_limit_field_out,
  input wire logic [12:0] z_limit_field_out,
  input wire logic [6:0] temp_limit_code_out,
  input wire logic temp_channel_on_out,
  input wire logic [3:0] match_flags_out,
  input wire logic threshold_event_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic wr3;
  logic wr4;
  logic wr6;
  logic wr7;
  assign wr3 = reg_wr_in && reg_addr_in == stc_pkg::OFF_SETUP_TWO;
  assign wr4 = reg_wr_in && reg_addr_in == stc_pkg::OFF_X_LIMIT;
  assign wr6 = reg_wr_in && reg_addr_in == stc_pkg::OFF_Z_LIMIT;
  assign wr7 = reg_wr_in && reg_addr_in == stc_pkg::OFF_TEMP_SETUP;
  // Limit code in base-range units
  function automatic logic [12:0] scale(input logic [7:0] c, input logic dbl);
    return dbl ? {c, 5'h00} : {c[7], c, 4'h0};
  endfunction
  xy_range_a: assert property (wr3 |=> xy_range_double_out == $past(reg_wdata_in[1]))
    else $error("planar range bit not taken");
  z_range_a: assert property (wr3 |=> z_range_double_out == $past(reg_wdata_in[0]))
    else $error("vertical range bit not taken");
  temp_on_a: assert property (wr7 |=> temp_channel_on_out == $past(reg_wdata_in[0]))
    else $error("temperature channel enable not taken");
  temp_code_a: assert property (wr7 |=> temp_limit_code_out == $past(reg_wdata_in[7:1]))
    else $error("temperature limit code not taken");
  x_field_a: assert property (wr4 ##1 !reg_wr_in |=>
    x_limit_field_out == scale($past(reg_wdata_in, 2), xy_range_double_out))
    else $error("x limit scaling wrong");
  z_field_a: assert property (wr6 ##1 !reg_wr_in |=>
    z_limit_field_out == scale($past(reg_wdata_in, 2), z_range_double_out))
    else $error("z limit scaling wrong");
  angle_off_a: assert property (wr3 && reg_wdata_in[3:2] == 2'h0 ##1 !reg_wr_in |=>
    !angle_on_out && gain_first_out == 8'h00 && gain_second_out == 8'h00)
    else $error("angle pair off still routes gain");
  zero_x_a: assert property (result_valid_in && result_axis_in == 2'h0 &&
    x_limit_field_out == 13'h0000 && !$past(reg_wr_in) |=> !match_flags_out[0])
    else $error("x matched with zero limit");
  zero_temp_a: assert property (result_valid_in && result_axis_in == 2'h3 &&
    temp_limit_code_out == 7'h00 |=> !match_flags_out[3] && !threshold_event_out)
    else $error("temperature matched with zero limit");
  event_cause_a: assert property (threshold_event_out |->
    $past(result_valid_in) && match_flags_out[$past(result_axis_in)])
    else $error("event without a matching result");
  unmapped_rd_a: assert property (reg_rd_in && reg_addr_in > 8'h07 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  cover property (threshold_event_out);
  cover property (wr3 && reg_wdata_in[3:2] == 2'h0);
  cover property (result_valid_in && result_axis_in == 2'h3);
endmodule // stc_checker

// file: sim/stc_host_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes strobes are sampled on the rising edge of mclk_in.
`timescale 1ns/1ns
module stc_host_model (
  input wire logic mclk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_wr_out = 1'h0;
    reg_rd_out = 1'h0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'h1;
    @(negedge mclk_in);
    reg_wr_out = 1'h0;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_rd_out = 1'h1;
    @(negedge mclk_in);
    d = reg_rdata_in;
    reg_rd_out = 1'h0;
  endtask
endmodule // stc_host_model

// file: sim/stc_tb_top.sv
// Self-checking bench of the threshold setup block.
// Assumes the host model on the register port; results driven here.
`timescale 1ns/1ns
module stc_tb_top;
  logic mclk_in, nrst_in, reg_wr_in, reg_rd_in, result_valid_in, threshold_event_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, gain_value_in, gain_first_out, gain_second_out;
  logic [2:0] band_select_in;
  logic [1:0] result_axis_in, angle_first_out, angle_second_out;
  logic [11:0] result_data_in;
  logic angle_on_out, xy_range_double_out, z_range_double_out, temp_channel_on_out;
  logic [12:0] x_limit_field_out, y_limit_field_out, z_limit_field_out;
  logic [6:0] temp_limit_code_out;
  logic [3:0] match_flags_out;
  int n_errors = 0;
  int tests_run = 0;
  logic [1:0] fst [4] = '{2'h0, 2'h0, 2'h1, 2'h0};
  logic [1:0] snd [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  stc_host_model host (.mclk_in, .reg_rdata_in(reg_rdata_out), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
  stc_top dut (.*);
  initial begin
    mclk_in = 1'h0;
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check("read data", {16'h0000, d}, {16'h0000, exp});
  endtask
  // One result, then event and that axis flag
  task automatic res(input logic [1:0] ax, input logic [11:0] d, input logic ev, input logic fl);
    @(negedge mclk_in);
    result_axis_in = ax;
    result_data_in = d;
    result_valid_in = 1'h1;
    @(negedge mclk_in);
    result_valid_in = 1'h0;
    check("event and flag", {22'h0, threshold_event_out, match_flags_out[ax]}, {22'h0, ev, fl});
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    end_of_test();
  end
  initial begin
    nrst_in = 1'h0;
    result_valid_in = 1'h0;
    result_axis_in = 2'h0;
    result_data_in = 12'h000;
    band_select_in = 3'h0;
    gain_value_in = 8'h5A;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    nrst_in = 1'h1;
    for (int a = 3; a < 8; a++) rdchk(a[7:0], 8'h00);
    host.wr(stc_pkg::OFF_SETUP_TWO, 8'hFF);
    rdchk(stc_pkg::OFF_SETUP_TWO, 8'h7F);
    host.wr(8'h09, 8'h55);
    rdchk(8'h09, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr(stc_pkg::OFF_SETUP_TWO, {3'h0, i[0], i[1:0], 2'h0});
      @(negedge mclk_in);
      check("angle pair", {3'h0, angle_on_out, angle_first_out, angle_second_out, gain_first_out,
        gain_second_out}, {3'h0, i != 0, fst[i], snd[i], (i != 0 && !i[0]) ? 8'h5A : 8'h00,
        (i != 0 && i[0]) ? 8'h5A : 8'h00});
    end
    for (int r = 0; r < 2; r++) begin
      host.wr(stc_pkg::OFF_SETUP_TWO, {6'h00, r[0], !r[0]});
      host.wr(stc_pkg::OFF_X_LIMIT, 8'h10);
      host.wr(stc_pkg::OFF_Y_LIMIT, 8'h80);
      host.wr(stc_pkg::OFF_Z_LIMIT, 8'h7F);
      @(negedge mclk_in);
      check("x field", {11'h0, x_limit_field_out}, r ? 24'h0200 : 24'h0100);
      check("y field", {11'h0, y_limit_field_out}, r ? 24'h1000 : 24'h1800);
      check("z field", {11'h0, z_limit_field_out}, r ? 24'h07F0 : 24'h0FE0);
    end
    rdchk(stc_pkg::OFF_Y_LIMIT, 8'h80);
    host.wr(stc_pkg::OFF_TEMP_SETUP, 8'h35);
    check("temp setup", {16'h0, temp_limit_code_out, temp_channel_on_out}, 24'h35);
    rdchk(stc_pkg::OFF_TEMP_SETUP, 8'h35);
    host.wr(stc_pkg::OFF_X_LIMIT, 8'h01);
    host.wr(stc_pkg::OFF_SETUP_TWO, 8'h00);
    res(2'h0, 12'h020, 1'h1, 1'h1);
    res(2'h0, 12'h020, 1'h0, 1'h1);
    res(2'h0, 12'h010, 1'h0, 1'h0);
    host.wr(stc_pkg::OFF_SETUP_TWO, 8'h20);
    res(2'h0, 12'h00F, 1'h1, 1'h1);
    res(2'h0, 12'h020, 1'h0, 1'h0);
    band_select_in = 3'h1;
    host.wr(stc_pkg::OFF_SETUP_TWO, 8'h00);
    res(2'h0, 12'hFE0, 1'h1, 1'h1);
    res(2'h0, 12'h000, 1'h0, 1'h0);
    host.wr(stc_pkg::OFF_SETUP_TWO, 8'h20);
    res(2'h0, 12'h000, 1'h1, 1'h1);
    res(2'h0, 12'h020, 1'h0, 1'h0);
    band_select_in = 3'h2;
    res(2'h0, 12'h018, 1'h0, 1'h0);
    res(2'h0, 12'h019, 1'h1, 1'h1);
    res(2'h0, 12'h000, 1'h0, 1'h0);
    band_select_in = 3'h7;
    res(2'h0, 12'h110, 1'h0, 1'h0);
    res(2'h0, 12'h111, 1'h1, 1'h1);
    band_select_in = 3'h0;
    host.wr(stc_pkg::OFF_SETUP_TWO, 8'h00);
    res(2'h0, 12'h000, 1'h0, 1'h0);
    host.wr(stc_pkg::OFF_Y_LIMIT, 8'h00);
    res(2'h1, 12'h7FF, 1'h0, 1'h0);
    res(2'h2, 12'h7F1, 1'h1, 1'h1);
    res(2'h2, 12'h000, 1'h0, 1'h0);
    res(2'h3, 12'h01B, 1'h1, 1'h1);
    res(2'h3, 12'h01A, 1'h0, 1'h0);
    host.wr(stc_pkg::OFF_TEMP_SETUP, 8'h02);
    res(2'h3, 12'h019, 1'h0, 1'h0);
    host.wr(stc_pkg::OFF_TEMP_SETUP, 8'h00);
    res(2'h3, 12'h07F, 1'h0, 1'h0);
    host.wr(stc_pkg::OFF_SETUP_TWO, 8'h40);
    for (int k = 0; k < 4; k++) begin
      res(2'h0, 12'h020, k == 3, 1'h1);
      res(2'h0, 12'h000, 1'h0, 1'h0);
    end
    host.wr(stc_pkg::OFF_X_LIMIT, 8'h00);
    res(2'h0, 12'h7FF, 1'h0, 1'h0);
    end_of_test();
  end
endmodule // stc_tb_top
bind stc_top stc_checker chk (.mclk_in, .nrst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
  .reg_wdata_in, .reg_rdata_out, .result_valid_in, .result_axis_in, .angle_on_out,
  .gain_first_out, .gain_second_out, .xy_range_double_out, .z_range_double_out,
  .x_limit_field_out, .z_limit_field_out, .temp_limit_code_out, .temp_channel_on_out,
  .match_flags_out, .threshold_event_out);
